// [rtl/vid_out_pkg.sv]
package vid_out_pkg;

  // ****************************************
  // sample formats
  // ****************************************
  localparam logic [7:0] LUMA_MIN      = 8'h10;  // lowest luma code
  localparam logic [7:0] CODE_MAX      = 8'hFF;  // top code, luma and chroma
  localparam logic [7:0] WHITE_PEAK    = 8'hF8;  // gain cut above this code

  // ****************************************
  // line timing, gain and buffer depth
  // ****************************************
  localparam int         CLK_HZ        = 20000000;
  localparam int         LINE_TIME_NS  = 64000;  // free-run line period
  localparam int         LINE_CYCLES   = (LINE_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int         CNT_W         = 12;
  localparam logic [CNT_W-1:0] SYNC_BEGIN_RST = 12'h000;
  localparam logic [CNT_W-1:0] SYNC_END_RST   = 12'h05C;
  localparam logic [CNT_W-1:0] LINE_LAST_RST  = 12'h4FF;
  localparam logic [7:0] GAIN_RST      = 8'h80;  // unity gain code
  localparam logic [7:0] GAIN_MIN      = 8'h01;
  localparam int         BUF_DEPTH     = 2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } pixel_s;

  typedef struct packed {
    logic       valid;
    logic       isRed;    // chroma phase of input sample
    logic [7:0] luma;
    logic [7:0] cb;
    logic [7:0] cr;
  } sample_s;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN   = 3'b010,
    ST_SYNC  = 3'b100
  } out_state_e;

endpackage

// [rtl/video_out_port.sv]
`timescale 1ns/100ps
// Function
// - chroma alternates blue and red, 4:2:2
// - every line starts with blue chroma
// - chroma unsigned, full 0 to 255
// - luma unsigned, clamped 16 to 255
// - peak enable: cut gain above 248
// - peak disabled: saturate at 255
// - all pins except the reset synchronous to master clock
// - asynchronous reset initialises all state
// - valid high exactly when buses valid
// - valid tri-stated after any reset
// - line sync on detected horizontal sync
// - line sync free-runs without video
// - programmable sync begin and end
// - line sync tri-stated after reset
module video_out_port
  import vid_out_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH  // output buffer entries
)(
  input  wire logic             ref_clk,          // master clock
  input  wire logic             rst_n,            // async reset, active low
  input  wire logic             softReset,        // software reset pulse
  input  wire sample_s          sampleIn,         // decoded sample stream
  output logic                  sampleReady,      // buffer can take a sample
  input  wire logic             lineStart,        // detected horizontal sync
  input  wire logic             videoPresent,     // input video detected
  input  wire logic [CNT_W-1:0] syncBegin,        // sync start, clocks
  input  wire logic [CNT_W-1:0] syncEnd,          // sync end, clocks
  input  wire logic [CNT_W-1:0] lineLast,         // free-run line length - 1
  input  wire logic             white_peak_limit_enable, // white peak enable
  input  wire logic [7:0]       adcCode,          // raw converter code
  output logic [7:0]            ampGain,          // video amplifier gain
  input  wire logic             sinkReady,        // receiver accepts word
  output logic [7:0]            lumaOut,          // luma bus
  output logic [7:0]            chroma_out_bus,   // chroma bus
  output logic                  sample_valid_out, // sample-valid pin level
  output logic                  sampleValidOe_n,  // sample-valid enable, low drives
  output logic                  lineSyncOut,      // line sync pin level
  output logic                  lineSyncOe_n      // line sync enable, low drives
);

  // refuse depths that the one-bit pointers cannot serve
  if (DEPTH != 2)
  begin : g_bad_depth
    $error("video_out_port: only a two-entry buffer is supported");
  end

  // ****************************************
  // reset and output state
  // ****************************************
  out_state_e state_r;
  out_state_e state_nxt;
  logic       running;
  logic       lineRef;      // detected or free-run line start

  // leave reset state only on the first line reference
  always_comb
  begin
    case (state_r)
      ST_RESET: state_nxt = lineRef ? ST_RUN : ST_RESET;
      ST_RUN:   state_nxt = ST_RUN;
      ST_SYNC:  state_nxt = ST_RUN;
      default:  state_nxt = ST_RESET;
    endcase
    if (softReset)
      state_nxt = ST_RESET;
  end

  // state register, back to reset on the reset pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end

  // pins are driven only once a line reference has been seen
  assign running = (state_r != ST_RESET);

  // ****************************************
  // line timing
  // ****************************************
  logic [CNT_W-1:0] lineCnt_r;
  logic [CNT_W-1:0] lineCnt_nxt;
  logic             freeWrap;
  logic             afterBegin;
  logic             beforeEnd;
  logic             syncOn_r;
  logic             syncOn_nxt;

  // free-run wrap when video absent, else detected sync restarts the line
  assign freeWrap    = !videoPresent && (lineCnt_r == lineLast);
  assign lineRef     = (videoPresent && lineStart) || freeWrap;
  assign lineCnt_nxt = lineRef ? '0 : lineCnt_r + 1'b1;
  // pulse spans begin to end, both counted in master clocks
  assign afterBegin  = (lineCnt_nxt >= syncBegin);
  assign beforeEnd   = (lineCnt_nxt < syncEnd);
  assign syncOn_nxt  = running && afterBegin && beforeEnd;

  // line counter and registered sync level, cleared by soft reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lineCnt_r <= '0;
      syncOn_r  <= 1'b0;
    end
    else
    begin
      lineCnt_r <= softReset ? '0 : lineCnt_nxt;
      syncOn_r  <= softReset ? 1'b0 : syncOn_nxt;
    end
  end

  // sync pin level and its release while in reset
  assign lineSyncOut  = syncOn_r;
  assign lineSyncOe_n = !running;

  // ****************************************
  // white peak gain control
  // ****************************************
  logic [7:0] gain_r;
  logic [7:0] gain_nxt;
  logic       peakHit;

  // enabled: step gain down while the code exceeds the peak threshold
  assign peakHit  = white_peak_limit_enable && (adcCode > WHITE_PEAK);
  // disabled: gain is forced back to unity, converter saturates at its top code
  assign gain_nxt = !white_peak_limit_enable ? GAIN_RST :
                    (peakHit && gain_r > GAIN_MIN) ? gain_r - 1'b1 : gain_r;

  // gain register, unity after reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gain_r <= GAIN_RST;
    else
      gain_r <= gain_nxt;
  end

  // gain leaves straight from its register
  assign ampGain = gain_r;

  // ****************************************
  // chroma phase and sample formatting
  // ****************************************
  logic       redPhase_r;
  logic       takeIn;
  pixel_s     pixIn;
  logic [7:0] lumaClamp;

  // take a sample only when running and the buffer has room
  assign takeIn    = sampleIn.valid && sampleReady && running;
  assign lumaClamp = (sampleIn.luma < LUMA_MIN) ? LUMA_MIN : sampleIn.luma;
  assign pixIn.luma   = lumaClamp;
  // chroma passes the full unsigned range untouched
  assign pixIn.chroma = redPhase_r ? sampleIn.cr : sampleIn.cb;

  // phase toggles per taken sample, forced to blue at each line start
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      redPhase_r <= 1'b0;
    else if (lineRef || softReset)
      redPhase_r <= 1'b0;
    else if (takeIn)
      redPhase_r <= !redPhase_r;
  end

  // ****************************************
  // two-entry output buffer
  // ****************************************
  pixel_s    mem_r [DEPTH];
  logic      wrPtr_r;
  logic      rdPtr_r;
  logic [1:0] count_r;
  logic      popOut;
  logic      outValid_r;
  pixel_s    outData_r;
  logic      loadOut;

  // room while not full, move a word out when the register is free
  assign sampleReady = (count_r != 2'(DEPTH));
  assign loadOut     = (count_r != 2'h0) && (!outValid_r || sinkReady);
  assign popOut      = loadOut;

  // one storage word per entry, written at the write pointer
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          mem_r[gi] <= '0;
        else if (takeIn && (wrPtr_r == 1'(gi)))
          mem_r[gi] <= pixIn;
      end
    end
  endgenerate

  // pointers and fill level, flushed by soft reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else if (softReset)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r ^ takeIn;
      rdPtr_r <= rdPtr_r ^ popOut;
      count_r <= count_r + {1'b0, takeIn} - {1'b0, popOut};
    end
  end

  // output register, valid held until receiver accepts
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outValid_r <= 1'b0;
      outData_r  <= '0;
    end
    else if (softReset)
      outValid_r <= 1'b0;
    else if (loadOut)
    begin
      outValid_r <= 1'b1;
      outData_r  <= mem_r[rdPtr_r];
    end
    else if (sinkReady)
      outValid_r <= 1'b0;
  end

  // data and valid pins from the output register
  assign lumaOut          = outData_r.luma;
  assign chroma_out_bus   = outData_r.chroma;
  assign sample_valid_out = outValid_r;
  assign sampleValidOe_n  = !running;

  // ****************************************
  // checks
  // ****************************************
  luma_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outValid_r |-> (lumaOut >= LUMA_MIN))
    else $error("luma below floor");

  blue_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lineRef |=> !redPhase_r)
    else $error("line did not restart on blue");

  chroma_alt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeIn && !lineRef && !softReset) |=> (redPhase_r != $past(redPhase_r)))
    else $error("chroma phase did not alternate");

  peak_cut_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (peakHit && gain_r > GAIN_MIN) |=> (gain_r == $past(gain_r) - 8'h01))
    else $error("gain not reduced at white peak");

  peak_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !white_peak_limit_enable |=> (ampGain == GAIN_RST))
    else $error("gain changed with peak limit off");

  valid_hiz_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    softReset |=> (sampleValidOe_n && !sample_valid_out))
    else $error("valid driven after soft reset");

  sync_hiz_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !running |-> (lineSyncOe_n && !lineSyncOut))
    else $error("line sync driven in reset");

  free_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (freeWrap && !softReset) |=> (lineCnt_r == '0))
    else $error("free-run counter did not wrap");

  sync_pos_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (running && !softReset && lineCnt_nxt == syncBegin && syncBegin < syncEnd)
      |=> lineSyncOut)
    else $error("sync did not start at begin");

  valid_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (outValid_r && !sinkReady && !softReset) |=> (outValid_r && $stable(outData_r)))
    else $error("valid word dropped under stall");

  count_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    count_r <= 2'(DEPTH))
    else $error("buffer fill above depth");

  load_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadOut && !softReset) |=> outValid_r)
    else $error("loaded word not flagged valid");

  valid_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (outValid_r && sinkReady && count_r == 2'h0 && !softReset) |=> !outValid_r)
    else $error("valid left high with no word");

  valid_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !running |-> (sampleValidOe_n && !sample_valid_out))
    else $error("valid driven in reset");

  gain_floor_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ampGain >= GAIN_MIN)
    else $error("gain below floor");

  gain_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (white_peak_limit_enable && !peakHit) |=> $stable(gain_r))
    else $error("gain moved below the peak code");

  sync_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (running && lineCnt_nxt == syncEnd) |=> !lineSyncOut)
    else $error("sync did not stop at end");

  line_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lineRef |=> (lineCnt_r == '0))
    else $error("line reference did not restart count");

  count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!lineRef && !softReset) |=> (lineCnt_r == $past(lineCnt_r) + 1'b1))
    else $error("line count skipped a clock");

  run_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lineRef && !softReset) |=> running)
    else $error("outputs not driven after line reference");

  soft_flush_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    softReset |=> (count_r == 2'h0 && !running))
    else $error("soft reset left state behind");

  state_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot(state_r))
    else $error("state code not one-hot");

endmodule // video_out_port

// [testbench/pixel_sink.sv]
`timescale 1ns/100ps
// ****
// receiver model
// ****
module pixel_sink
  import vid_out_pkg::*;
(
  input  wire logic       ref_clk,        // master clock
  input  wire logic       stall,          // hold the receiver off
  input  wire logic [7:0] lumaOut,        // luma bus
  input  wire logic [7:0] chroma_out_bus, // chroma bus
  input  wire logic       validPin,       // resolved valid pin
  output logic            sinkReady       // accepts a word
);
  pixel_s got[$];
  initial sinkReady = 1'b0;
  // ready is the inverse of stall, moved just after the edge
  always @(posedge ref_clk) sinkReady <= #2 !stall;
  // words are taken only on edges where valid is high
  always @(posedge ref_clk)
    if (validPin === 1'b1 && sinkReady === 1'b1) got.push_back({lumaOut, chroma_out_bus});
endmodule // pixel_sink

// [testbench/video_decoder_output_port_test.sv]
`timescale 1ns/100ps
// ****
// bench top
// ****
module video_decoder_output_port_test
  import vid_out_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, softReset = 1'b0, lineStart = 1'b0;
  logic videoPresent = 1'b0, white_peak_limit_enable = 1'b0, stall = 1'b0;
  logic [CNT_W-1:0] syncBegin = 12'h003, syncEnd = 12'h009, lineLast = 12'h01F;
  logic [7:0] adcCode = 8'h00;
  sample_s sampleIn = '0;
  logic sampleReady, sinkReady, sample_valid_out, sampleValidOe_n, lineSyncOut, lineSyncOe_n;
  logic [7:0] ampGain, lumaOut, chroma_out_bus;
  int fails = 0, n_checks = 0, cycles = 0;
  wire validPin = sampleValidOe_n ? 1'b1 : sample_valid_out; // pull-up when released

  video_out_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .softReset(softReset),
    .sampleIn(sampleIn), .sampleReady(sampleReady), .lineStart(lineStart),
    .videoPresent(videoPresent), .syncBegin(syncBegin), .syncEnd(syncEnd),
    .lineLast(lineLast), .white_peak_limit_enable(white_peak_limit_enable),
    .adcCode(adcCode),
    .ampGain(ampGain), .sinkReady(sinkReady), .lumaOut(lumaOut),
    .chroma_out_bus(chroma_out_bus), .sample_valid_out(sample_valid_out),
    .sampleValidOe_n(sampleValidOe_n), .lineSyncOut(lineSyncOut),
    .lineSyncOe_n(lineSyncOe_n));
  pixel_sink sink (.ref_clk(ref_clk), .stall(stall), .lumaOut(lumaOut),
    .chroma_out_bus(chroma_out_bus), .validPin(validPin), .sinkReady(sinkReady));

  // clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check_bit(input logic a, input logic e);
    n_checks++;
    if (a !== e)
    begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, a, e);
    end
  endtask
  task automatic check_byte(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e)
    begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, a, e);
    end
  endtask
  task automatic check_word(input logic [11:0] a, input logic [11:0] e);
    n_checks++;
    if (a !== e)
    begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, a, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // offer one sample and hold it until the edge that takes it
  task automatic send(input logic [7:0] l, input logic [7:0] cb, input logic [7:0] cr);
    sampleIn = {1'b1, 1'b0, l, cb, cr};
    while (sampleReady !== 1'b1) tick(1);
    tick(1);
  endtask
  task automatic pulse_line();
    lineStart = 1'b1;
    tick(1);
    lineStart = 1'b0;
  endtask

  // pins released and gain at rest while reset is held
  task automatic t_reset();
    tick(6);
    check_bit(sampleValidOe_n, 1'b1);
    check_bit(lineSyncOe_n, 1'b1);
    check_byte(ampGain, GAIN_RST);
    rst_n = 1'b1;
  endtask
  // free-running line sync width and period
  task automatic t_free();
    logic [11:0] n;
    n = '0;
    while (lineSyncOe_n !== 1'b0) tick(1);
    check_bit(sampleValidOe_n, 1'b0);
    while (lineSyncOut !== 1'b1) tick(1);
    while (lineSyncOut === 1'b1)
    begin
      n++;
      tick(1);
    end
    check_word(n, syncEnd - syncBegin);
    while (lineSyncOut !== 1'b1)
    begin
      n++;
      tick(1);
    end
    check_word(n, lineLast + 12'h001);
  endtask
  // stalled stream, clamping, chroma order and restart per line
  task automatic t_stream();
    lineLast = 12'hFFF;
    videoPresent = 1'b1;
    stall = 1'b1;
    pulse_line();
    tick(2);
    sink.got.delete();
    send(8'h05, 8'h00, 8'h11);
    send(8'hFF, 8'h22, 8'hFF);
    send(8'h40, 8'h33, 8'h44);
    check_bit(sampleReady, 1'b0);      // buffer full under stall
    check_bit(sample_valid_out, 1'b1);
    stall = 1'b0;
    sampleIn.valid = 1'b0;
    tick(6);
    pulse_line();
    send(8'h20, 8'h77, 8'h88);
    sampleIn.valid = 1'b0;
    tick(6);
    check_word(12'(sink.got.size()), 12'h004);
    check_byte(sink.got[0].luma, LUMA_MIN);
    check_byte(sink.got[1].luma, CODE_MAX);
    check_byte(sink.got[0].chroma, 8'h00);
    check_byte(sink.got[1].chroma, 8'hFF);
    check_byte(sink.got[2].chroma, 8'h33);
    check_byte(sink.got[3].chroma, 8'h77);
  endtask
  // gain cut only above the peak code, and only when enabled
  task automatic t_peak();
    white_peak_limit_enable = 1'b1;
    adcCode = WHITE_PEAK + 8'h01;
    tick(3);
    check_byte(ampGain, GAIN_RST - 8'h03);
    adcCode = WHITE_PEAK;
    tick(3);
    check_byte(ampGain, GAIN_RST - 8'h03);
    white_peak_limit_enable = 1'b0;
    adcCode = CODE_MAX;
    tick(2);
    check_byte(ampGain, GAIN_RST);
  endtask
  // software reset releases both pins again
  task automatic t_soft();
    softReset = 1'b1;
    tick(1);
    softReset = 1'b0;
    check_bit(sampleValidOe_n, 1'b1);
    check_bit(lineSyncOe_n, 1'b1);
  endtask

  // main sequence
  initial
  begin
    t_reset();
    t_free();
    t_stream();
    t_peak();
    t_soft();
    give_verdict();
  end
endmodule // video_decoder_output_port_test
